// File: rtl/virt_part_map_regs.sv
// How it works
// - register three maps virtual identifiers 12..15
// - register four maps virtual identifiers 16..19
// - id field reports highest register index, max 7
// - index zero means only register zero exists
// - per-level enables gate kernel and user translation
// - entry used only when its valid bit set
// - absent registers make direct accesses undefined
// - no translation effect when hypervisor level off
// - entries reset to zero; software writes before use
// - four 16-bit entries, highest identifier in top
// - op0 11, op1 100, CRn 1010, CRm 0110
// - user never, monitor always, hyp when enabled
// - nested redirect sends kernel access to memory
// - lower trap sends hyp accesses to monitor
// - lower trap with nested-only sends kernel to monitor
// - host extension nested-only sends kernel to hyp
`include "vpm_cfg.svh"
`default_nettype none
module virt_part_map_regs #(
  parameter logic [2:0] HIGHEST_MAP_REG_INDEX = 3'h7,
  parameter bit HYP_CONTROL_PRESENT = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // system register move request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire vpm_pkg::exc_level_e req_level_i,
  input wire logic [1:0] req_op0_i,
  input wire logic [2:0] req_op1_i,
  input wire logic [3:0] req_crn_i,
  input wire logic [3:0] req_crm_i,
  input wire logic [2:0] req_op2_i,
  input wire logic [63:0] req_wdata_i,
  output logic req_ready_o,
  // answer to the request
  output logic resp_valid_o,
  output logic resp_match_o,
  output logic [63:0] resp_rdata_o,
  output logic resp_undef_o,
  output logic resp_trap_hyp_o,
  output logic resp_trap_mon_o,
  output logic resp_redirect_o,
  output logic [63:0] resp_redirect_addr_o,
  // controls from other system registers
  input wire logic lower_level_trap_ctrl_i,
  input wire logic nested_virt_ctrl_i,
  input wire logic nested_virt_redirect_ctrl_i,
  input wire logic trap_general_exceptions_i,
  input wire logic host_extension_ctrl_i,
  input wire logic hyp_aarch64_i,
  input wire logic security_state_bit_i,
  input wire logic secure_hyp_level_enable_i,
  input wire logic [51:0] redirect_base_field_i,
  input wire logic kernel_level_map_enable_i,
  input wire logic user_level_map_enable_i,
  input wire logic [31:0] map_entry_valid_bits_i,
  // identification
  output logic [2:0] highest_map_reg_index_o,
  output logic hyp_control_present_flag_o,
  // translation port
  input wire logic xlat_valid_i,
  input wire logic [15:0] xlat_virt_id_i,
  input wire logic xlat_from_kernel_i,
  output logic xlat_valid_o,
  output logic [15:0] xlat_phys_id_o,
  output logic xlat_hit_o
);
  import vpm_pkg::*;

  // the index field is three bits wide, so anything past 7 cannot exist
  initial begin
    if (HIGHEST_MAP_REG_INDEX > `VPM_IDX_LIMIT) begin
      $error("highest map register index out of range");
    end
  end

  // all state of the block
  typedef struct packed {
    seq_state_e state;
    map_reg_t map_three;
    map_reg_t map_four;
    logic match;
    logic [63:0] rdata;
    logic undef;
    logic trap_hyp;
    logic trap_mon;
    logic redirect;
    logic [63:0] redirect_addr;
    logic xvalid;
    logic [15:0] xphys;
    logic xhit;
  } regs_s;

  regs_s cur;
  regs_s next_cur;

  // decode of the request
  logic enc_base;
  logic sel_three;
  logic sel_four;
  logic present_three;
  logic present_four;
  logic present;
  logic hyp_enabled;
  access_e verdict;
  logic [63:0] redirect_addr;
  logic [15:0] lk_phys;
  logic lk_hit;

  // true when the shared encoding fields name this register pair
  function automatic logic enc_is_ours(input logic [1:0] op0,
      input logic [2:0] op1, input logic [3:0] crn,
      input logic [3:0] crm);
    enc_is_ours = (op0 == `VPM_OP0) && (op1 == `VPM_OP1) &&
        (crn == `VPM_CRN) && (crm == `VPM_CRM);
  endfunction

  // presence of a register; hypervisor control present and the highest index must exceed the given value
  function automatic logic reg_present(input logic [2:0] min_idx);
    reg_present = HYP_CONTROL_PRESENT &&
        (HIGHEST_MAP_REG_INDEX > min_idx);
  endfunction

  // replace the addressed register word with write data, per entry
  function automatic map_reg_t pack_entries(input logic [63:0] w);
    map_reg_t r;
    r = '0;
    for (int i = 0; i < `VPM_ENTRIES; i++) begin
      r[i] = w[i*`VPM_ENTRY_W +: `VPM_ENTRY_W];
    end
    pack_entries = r;
  endfunction

  assign enc_base = enc_is_ours(req_op0_i, req_op1_i, req_crn_i,
      req_crm_i);
  assign sel_three = enc_base && (req_op2_i == `VPM_OP2_THREE);
  assign sel_four = enc_base && (req_op2_i == `VPM_OP2_FOUR);

  // index zero implies only register zero, so neither of ours exists
  assign present_three = reg_present(`VPM_MIN_IDX_THREE);
  assign present_four = reg_present(`VPM_MIN_IDX_FOUR);
  assign present = (sel_three && present_three) ||
      (sel_four && present_four);

  // hypervisor level is enabled in non-secure state or with secure EL2
  assign hyp_enabled = security_state_bit_i | secure_hyp_level_enable_i;

  // identification outputs are constants of the build
  assign highest_map_reg_index_o = HIGHEST_MAP_REG_INDEX;
  assign hyp_control_present_flag_o = HYP_CONTROL_PRESENT;

  // access verdict from level and trap controls
  vpm_access_check u_check (
    .level_i(req_level_i),
    .present_i(present),
    .lower_level_trap_ctrl_i(lower_level_trap_ctrl_i),
    .nested_virt_ctrl_i(nested_virt_ctrl_i),
    .nested_virt_redirect_ctrl_i(nested_virt_redirect_ctrl_i),
    .trap_general_exceptions_i(trap_general_exceptions_i),
    .host_extension_ctrl_i(host_extension_ctrl_i),
    .hyp_aarch64_i(hyp_aarch64_i),
    .security_state_bit_i(security_state_bit_i),
    .secure_hyp_level_enable_i(secure_hyp_level_enable_i),
    .verdict_o(verdict)
  );

  // redirected kernel accesses land in memory at offset 0x958 or 0x960 within the base page
  assign redirect_addr = {redirect_base_field_i, 12'h000} +
      (sel_four ? `VPM_REDIR_OFF_FOUR : `VPM_REDIR_OFF_THREE);

  // translation of identifiers 12 to 19
  vpm_lookup u_lookup (
    .virt_id_i(xlat_virt_id_i),
    .from_kernel_i(xlat_from_kernel_i),
    .kernel_level_map_enable_i(kernel_level_map_enable_i),
    .user_level_map_enable_i(user_level_map_enable_i),
    .hyp_enabled_i(hyp_enabled),
    .map_entry_valid_bits_i(map_entry_valid_bits_i),
    .map_three_i(cur.map_three),
    .map_four_i(cur.map_four),
    .phys_id_o(lk_phys),
    .hit_o(lk_hit)
  );

  // one request in flight; a new one is taken only when idle
  assign req_ready_o = (cur.state == ST_IDLE);

  // answer fields come straight from flip-flops
  assign resp_valid_o = (cur.state == ST_RESP);
  assign resp_match_o = cur.match;
  assign resp_rdata_o = cur.rdata;
  assign resp_undef_o = cur.undef;
  assign resp_trap_hyp_o = cur.trap_hyp;
  assign resp_trap_mon_o = cur.trap_mon;
  assign resp_redirect_o = cur.redirect;
  assign resp_redirect_addr_o = cur.redirect_addr;
  assign xlat_valid_o = cur.xvalid;
  assign xlat_phys_id_o = cur.xphys;
  assign xlat_hit_o = cur.xhit;

  // next state: sequencer, register update and lookup pipeline
  always_comb begin
    next_cur = cur;
    next_cur.xvalid = xlat_valid_i;
    if (xlat_valid_i) begin
      next_cur.xphys = lk_phys;
      next_cur.xhit = lk_hit;
    end
    case (cur.state)
      ST_IDLE: begin
        if (req_valid_i) begin
          next_cur.state = ST_RESP;
          // a foreign encoding is not ours; another bank answers it
          next_cur.match = sel_three || sel_four;
          next_cur.rdata = '0;
          next_cur.undef = 1'b0;
          next_cur.trap_hyp = 1'b0;
          next_cur.trap_mon = 1'b0;
          next_cur.redirect = 1'b0;
          next_cur.redirect_addr = '0;
          if (sel_three || sel_four) begin
            case (verdict)
              ACC_RW: begin
                if (req_write_i && sel_three) begin
                  next_cur.map_three = pack_entries(req_wdata_i);
                end else if (req_write_i) begin
                  next_cur.map_four = pack_entries(req_wdata_i);
                end else begin
                  // reads have no side effect on the stored entries
                  next_cur.rdata = sel_three ? cur.map_three :
                      cur.map_four;
                end
              end
              ACC_TRAP_HYP: next_cur.trap_hyp = 1'b1;
              ACC_TRAP_MON: next_cur.trap_mon = 1'b1;
              ACC_REDIRECT: begin
                next_cur.redirect = 1'b1;
                next_cur.redirect_addr = redirect_addr;
              end
              default: next_cur.undef = 1'b1;
            endcase
          end
        end
      end
      ST_RESP: next_cur.state = ST_IDLE;
      default: next_cur.state = ST_IDLE;
    endcase
  end

  // entries have no defined reset value for software; zero is used
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur <= '0;
      cur.state <= ST_IDLE;
      cur.map_three <= {`VPM_ENTRIES{`VPM_ENTRY_RESET}};
      cur.map_four <= {`VPM_ENTRIES{`VPM_ENTRY_RESET}};
    end else begin
      cur <= next_cur;
    end
  end
endmodule // virt_part_map_regs
`default_nettype wire

// File: rtl/vpm_access_check.sv
`include "vpm_cfg.svh"
`default_nettype none
module vpm_access_check (
  // request
  input wire vpm_pkg::exc_level_e level_i,
  input wire logic present_i,
  // controls
  input wire logic lower_level_trap_ctrl_i,
  input wire logic nested_virt_ctrl_i,
  input wire logic nested_virt_redirect_ctrl_i,
  input wire logic trap_general_exceptions_i,
  input wire logic host_extension_ctrl_i,
  input wire logic hyp_aarch64_i,
  input wire logic security_state_bit_i,
  input wire logic secure_hyp_level_enable_i,
  // verdict
  output vpm_pkg::access_e verdict_o
);
  import vpm_pkg::*;

  logic hyp_on;
  logic nv_only;
  logic nv_both;

  // hypervisor level usable in the current security state
  assign hyp_on = security_state_bit_i | secure_hyp_level_enable_i;
  assign nv_only = nested_virt_ctrl_i & ~nested_virt_redirect_ctrl_i;
  assign nv_both = nested_virt_ctrl_i & nested_virt_redirect_ctrl_i;

  // traps are checked before redirect; absent register is undefined
  always_comb begin
    verdict_o = ACC_UNDEF;
    if (present_i) begin
      case (level_i)
        EL_USER: verdict_o = ACC_UNDEF;
        EL_MONITOR: verdict_o = ACC_RW;
        EL_HYP: begin
          if (lower_level_trap_ctrl_i) verdict_o = ACC_TRAP_MON;
          else if (hyp_on) verdict_o = ACC_RW;
          else verdict_o = ACC_UNDEF;
        end
        EL_KERNEL: begin
          if (lower_level_trap_ctrl_i && nv_only) begin
            verdict_o = ACC_TRAP_MON;
          end else if (!lower_level_trap_ctrl_i && hyp_on && hyp_aarch64_i
              && host_extension_ctrl_i && nv_only) begin
            verdict_o = ACC_TRAP_HYP;
          end else if (nv_both && !(trap_general_exceptions_i && hyp_on))
              begin
            verdict_o = ACC_REDIRECT;
          end else begin
            verdict_o = ACC_UNDEF;
          end
        end
        default: verdict_o = ACC_UNDEF;
      endcase
    end
  end
endmodule // vpm_access_check
`default_nettype wire

// File: rtl/vpm_cfg.svh
`ifndef VPM_CFG_SVH
`define VPM_CFG_SVH

// system register encoding shared by both mapping registers
`define VPM_OP0 2'h3
`define VPM_OP1 3'h4
`define VPM_CRN 4'hA
`define VPM_CRM 4'h6
`define VPM_OP2_THREE 3'h3
`define VPM_OP2_FOUR 3'h4

// presence thresholds on the highest implemented index
`define VPM_MIN_IDX_THREE 3'h2
`define VPM_MIN_IDX_FOUR 3'h3
`define VPM_IDX_LIMIT 7

// entry layout: four 16-bit entries, lowest identifier at bit 0
`define VPM_ENTRY_W 16
`define VPM_ENTRIES 4
`define VPM_REG_W 64
`define VPM_ENTRY_RESET 16'h0000

// first virtual identifier of each register
`define VPM_FIRST_ID_THREE 16'h000C
`define VPM_FIRST_ID_FOUR 16'h0010
`define VPM_LAST_ID 16'h0013

// nested redirect memory layout
`define VPM_REDIR_SHIFT 12
`define VPM_REDIR_OFF_THREE 64'h0000000000000958
`define VPM_REDIR_OFF_FOUR 64'h0000000000000960

`endif

// File: rtl/vpm_lookup.sv
`include "vpm_cfg.svh"
`default_nettype none
module vpm_lookup (
  // virtual identifier and its source
  input wire logic [15:0] virt_id_i,
  input wire logic from_kernel_i,
  // enables
  input wire logic kernel_level_map_enable_i,
  input wire logic user_level_map_enable_i,
  input wire logic hyp_enabled_i,
  input wire logic [31:0] map_entry_valid_bits_i,
  // table for identifiers 12 to 19
  input wire vpm_pkg::map_reg_t map_three_i,
  input wire vpm_pkg::map_reg_t map_four_i,
  // result
  output logic [15:0] phys_id_o,
  output logic hit_o
);
  import vpm_pkg::*;

  logic enabled;
  logic in_range;
  logic [15:0] rel;
  logic [7:0][15:0] table_flat;

  assign table_flat = {map_four_i, map_three_i};
  // per-source enable, nothing applies without the hypervisor level
  assign enabled = hyp_enabled_i & (from_kernel_i ?
      kernel_level_map_enable_i : user_level_map_enable_i);
  assign in_range = (virt_id_i >= `VPM_FIRST_ID_THREE) &&
      (virt_id_i <= `VPM_LAST_ID);
  assign rel = virt_id_i - `VPM_FIRST_ID_THREE;

  // outside our range or invalid entry: identifier passes unchanged
  always_comb begin
    hit_o = 1'b0;
    phys_id_o = virt_id_i;
    if (enabled && in_range && map_entry_valid_bits_i[virt_id_i[4:0]]) begin
      hit_o = 1'b1;
      phys_id_o = table_flat[rel[2:0]];
    end
  end
endmodule // vpm_lookup
`default_nettype wire

// File: rtl/vpm_pkg.sv
`default_nettype none
package vpm_pkg;
  // exception level of the requesting instruction
  typedef enum logic [1:0] {
    EL_USER = 2'h0,
    EL_KERNEL = 2'h1,
    EL_HYP = 2'h2,
    EL_MONITOR = 2'h3
  } exc_level_e;

  // outcome of an access check
  typedef enum logic [2:0] {
    ACC_UNDEF = 3'h0,
    ACC_RW = 3'h1,
    ACC_TRAP_HYP = 3'h2,
    ACC_TRAP_MON = 3'h3,
    ACC_REDIRECT = 3'h4
  } access_e;

  // request sequencer, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } seq_state_e;

  typedef logic [3:0][15:0] map_reg_t;
endpackage : vpm_pkg
`default_nettype wire

// File: verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import vpm_pkg::*;
  localparam logic [63:0] W3 = 64'hABCD_1234_5678_9ABC;
  localparam logic [63:0] W4 = 64'h1111_2222_3333_4444;
  localparam logic [51:0] BASE = 52'hA_BCDE_F012_3456;
  // inputs, idle values at time zero
  logic ref_clk_i = 1'b0, arst_n_i = 1'b0;
  logic req_valid_i = 1'b0, req_write_i = 1'b0;
  exc_level_e req_level_i = EL_USER;
  logic [1:0] req_op0_i = 2'h3;
  logic [2:0] req_op1_i = 3'h4, req_op2_i = 3'h3;
  logic [3:0] req_crn_i = 4'hA, req_crm_i = 4'h6;
  logic [63:0] req_wdata_i = 64'h0;
  logic lower_level_trap_ctrl_i = 1'b0, nested_virt_ctrl_i = 1'b0;
  logic nested_virt_redirect_ctrl_i = 1'b0, trap_general_exceptions_i = 1'b0;
  logic host_extension_ctrl_i = 1'b0, hyp_aarch64_i = 1'b0;
  logic security_state_bit_i = 1'b0, secure_hyp_level_enable_i = 1'b0;
  logic [51:0] redirect_base_field_i = BASE;
  logic kernel_level_map_enable_i = 1'b0, user_level_map_enable_i = 1'b0;
  logic [31:0] map_entry_valid_bits_i = 32'h0;
  logic xlat_valid_i = 1'b0, xlat_from_kernel_i = 1'b0;
  logic [15:0] xlat_virt_id_i = 16'h0;
  // outputs
  logic req_ready_o, resp_valid_o, resp_match_o, resp_undef_o;
  logic resp_trap_hyp_o, resp_trap_mon_o, resp_redirect_o, xlat_valid_o;
  logic xlat_hit_o, hyp_control_present_flag_o;
  logic [63:0] resp_rdata_o, resp_redirect_addr_o;
  logic [2:0] highest_map_reg_index_o;
  logic [15:0] xlat_phys_id_o;
  int mismatches = 0, tests_run = 0;
  // verdict flags packed for one compare
  wire logic [4:0] flags;
  assign flags = {resp_match_o, resp_undef_o, resp_trap_hyp_o,
                  resp_trap_mon_o, resp_redirect_o};

  virt_part_map_regs u_virt_part_map_regs (
    .ref_clk_i, .arst_n_i, .req_valid_i, .req_write_i, .req_level_i,
    .req_op0_i, .req_op1_i, .req_crn_i, .req_crm_i, .req_op2_i,
    .req_wdata_i, .req_ready_o, .resp_valid_o, .resp_match_o,
    .resp_rdata_o, .resp_undef_o, .resp_trap_hyp_o, .resp_trap_mon_o,
    .resp_redirect_o, .resp_redirect_addr_o, .lower_level_trap_ctrl_i,
    .nested_virt_ctrl_i, .nested_virt_redirect_ctrl_i,
    .trap_general_exceptions_i, .host_extension_ctrl_i, .hyp_aarch64_i,
    .security_state_bit_i, .secure_hyp_level_enable_i,
    .redirect_base_field_i, .kernel_level_map_enable_i,
    .user_level_map_enable_i, .map_entry_valid_bits_i,
    .highest_map_reg_index_o, .hyp_control_present_flag_o, .xlat_valid_i,
    .xlat_virt_id_i, .xlat_from_kernel_i, .xlat_valid_o, .xlat_phys_id_o,
    .xlat_hit_o
  );

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // trap, nested, redirect, tge, e2h, aarch64, ns, secure_hyp_level_enable in one byte
  task automatic ctl(input logic [7:0] c);
    // change controls on the edge, never between edges
    @(posedge ref_clk_i);
    {lower_level_trap_ctrl_i, nested_virt_ctrl_i,
     nested_virt_redirect_ctrl_i, trap_general_exceptions_i,
     host_extension_ctrl_i, hyp_aarch64_i, security_state_bit_i,
     secure_hyp_level_enable_i} <= c;
  endtask

  // one request held until taken; returns just after the answer edge
  task automatic acc(input logic w, input exc_level_e lv,
                     input logic [2:0] op, input logic [63:0] wd);
    @(posedge ref_clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_level_i <= lv;
    req_op2_i <= op;
    req_wdata_i <= wd;
    #1;
    // ready sampled between edges, where it is settled
    while (req_ready_o !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
    end
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    #1;
  endtask

  task automatic xl(input logic [15:0] id, input logic k);
    @(posedge ref_clk_i);
    xlat_valid_i <= 1'b1;
    xlat_virt_id_i <= id;
    xlat_from_kernel_i <= k;
    @(posedge ref_clk_i);
    xlat_valid_i <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    chk("idle", {req_ready_o, resp_valid_o}, 2'b10);
    chk("index", highest_map_reg_index_o, 3'h7);
    chk("hcr flag", hyp_control_present_flag_o, 1'b1);
    acc(1'b0, EL_MONITOR, 3'h3, 64'h0);
    chk("reset entry", resp_rdata_o, 64'h0);
  endtask

  task automatic t_rw();
    ctl(8'h00);
    acc(1'b1, EL_MONITOR, 3'h3, W3);
    chk("flags", flags, 5'h10);
    acc(1'b1, EL_MONITOR, 3'h4, ~W4);
    ctl(8'h02);
    acc(1'b1, EL_HYP, 3'h4, W4);
    acc(0, EL_HYP, 3'h3, 0);
    chk("reg three", resp_rdata_o, W3);
    acc(0, EL_HYP, 3'h4, 0);
    chk("reg four", resp_rdata_o, W4);
    acc(1'b1, EL_USER, 3'h3, 64'h0);
    acc(0, EL_MONITOR, 3'h3, 0);
    chk("after user write", resp_rdata_o, W3);
  endtask

  task automatic t_levels();
    exc_level_e lv [13] = '{EL_USER, EL_HYP, EL_HYP, EL_HYP, EL_HYP,
      EL_KERNEL, EL_KERNEL, EL_KERNEL, EL_KERNEL, EL_KERNEL, EL_KERNEL,
      EL_MONITOR, EL_KERNEL};
    logic [7:0] cd [13] = '{8'h02, 8'h02, 8'h01, 8'h00, 8'h82, 8'hC2,
      8'h4E, 8'h62, 8'h60, 8'h72, 8'h02, 8'h80, 8'h4A};
    logic [4:0] ex [13] = '{5'h18, 5'h10, 5'h10, 5'h18, 5'h12, 5'h12,
      5'h14, 5'h11, 5'h11, 5'h18, 5'h18, 5'h10, 5'h18};
    for (int i = 0; i < 13; i++) begin
      ctl(cd[i]);
      acc(1'b0, lv[i], 3'h3, 64'h0);
      chk("verdict", flags, ex[i]);
      if (ex[i] == 5'h11) begin
        chk("addr three", resp_redirect_addr_o,
            {BASE, 12'h000} + 64'h958);
      end
    end
    ctl(8'h62);
    acc(1'b0, EL_KERNEL, 3'h4, 64'h0);
    chk("addr four", resp_redirect_addr_o, {BASE, 12'h000} + 64'h960);
  endtask

  task automatic t_foreign();
    req_crm_i <= 4'h5;
    acc(1'b1, EL_MONITOR, 3'h3, 64'h0);
    chk("crm foreign", flags, 5'h00);
    req_crm_i <= 4'h6;
    acc(1'b1, EL_MONITOR, 3'h5, 64'h0);
    chk("op2 foreign", flags, 5'h00);
    req_op0_i <= 2'h2;
    acc(1'b1, EL_MONITOR, 3'h3, 64'h0);
    chk("op0 foreign", flags, 5'h00);
    req_op0_i <= 2'h3;
    acc(1'b0, EL_MONITOR, 3'h3, 64'h0);
    chk("no write", resp_rdata_o, W3);
  endtask

  task automatic t_xlat();
    ctl(8'h02);
    kernel_level_map_enable_i <= 1'b1;
    map_entry_valid_bits_i <= 32'h0004_2000;
    xl(16'h000D, 1'b1);
    chk("id 13", {xlat_valid_o, xlat_hit_o, xlat_phys_id_o},
        {2'b11, W3[31:16]});
    xl(16'h0012, 1'b0);
    chk("user off", {xlat_hit_o, xlat_phys_id_o}, {1'b0, 16'h0012});
    user_level_map_enable_i <= 1'b1;
    xl(16'h0012, 1'b0);
    chk("id 18", {xlat_hit_o, xlat_phys_id_o}, {1'b1, W4[47:32]});
    xl(16'h000E, 1'b1);
    chk("invalid", {xlat_hit_o, xlat_phys_id_o}, {1'b0, 16'h000E});
    kernel_level_map_enable_i <= 1'b0;
    xl(16'h000D, 1'b1);
    chk("kernel off", {xlat_hit_o, xlat_phys_id_o}, {1'b0, 16'h000D});
    kernel_level_map_enable_i <= 1'b1;
    ctl(8'h00);
    xl(16'h000D, 1'b1);
    chk("hyp off", {xlat_hit_o, xlat_phys_id_o}, {1'b0, 16'h000D});
    ctl(8'h01);
    xl(16'h000D, 1'b1);
    chk("secure hyp", {xlat_hit_o, xlat_phys_id_o}, {1'b1, W3[31:16]});
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_rw();
    t_levels();
    t_foreign();
    t_xlat();
    stop_test();
  end

  // whole run is under a hundred cycles; this limit is ample
  initial begin
    #50us;
    mismatches++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire

// File: verification/vpm_regs_checker.sv
`default_nettype none
module vpm_regs_checker #(
  parameter logic [2:0] HIGHEST_MAP_REG_INDEX = 3'h7
) (
  // clock, request, controls
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic req_valid_i,
  input wire vpm_pkg::exc_level_e req_level_i,
  input wire logic [1:0] req_op0_i,
  input wire logic [2:0] req_op2_i,
  input wire logic lower_level_trap_ctrl_i,
  input wire logic [51:0] redirect_base_field_i,
  input wire logic security_state_bit_i,
  input wire logic secure_hyp_level_enable_i,
  input wire logic [31:0] map_entry_valid_bits_i,
  // answer and identification
  input wire logic req_ready_o,
  input wire logic resp_valid_o,
  input wire logic resp_match_o,
  input wire logic resp_undef_o,
  input wire logic resp_trap_mon_o,
  input wire logic resp_redirect_o,
  input wire logic [63:0] resp_redirect_addr_o,
  input wire logic [2:0] highest_map_reg_index_o,
  // translation
  input wire logic xlat_valid_i,
  input wire logic [15:0] xlat_virt_id_i,
  input wire logic xlat_valid_o,
  input wire logic [15:0] xlat_phys_id_o,
  input wire logic xlat_hit_o
);
  import vpm_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // request taken on this edge
  wire logic take;
  assign take = req_valid_i && req_ready_o;
  resp_answer_a: assert property (
      take |=> resp_valid_o ##1 !resp_valid_o)
    else $error("answer not a single pulse after take");
  busy_refuse_a: assert property (
      resp_valid_o |-> !req_ready_o)
    else $error("ready high during answer");
  ident_index_a: assert property (
      highest_map_reg_index_o == HIGHEST_MAP_REG_INDEX)
    else $error("index field differs from parameter");
  user_refused_a: assert property (
      take && req_level_i == EL_USER |=> !resp_match_o || resp_undef_o)
    else $error("user level access not undefined");
  hyp_trap_a: assert property (
      take && req_level_i == EL_HYP && lower_level_trap_ctrl_i
      |=> !resp_match_o || resp_trap_mon_o)
    else $error("hyp access not trapped to monitor");
  absent_reg_a: assert property (
      take && (req_op2_i == 3'h4 && HIGHEST_MAP_REG_INDEX <= 3'h3 ||
      req_op2_i == 3'h3 && HIGHEST_MAP_REG_INDEX <= 3'h2)
      |=> !resp_match_o || resp_undef_o)
    else $error("absent register accessible");
  foreign_enc_a: assert property (
      take && req_op0_i != 2'h3 |=> !resp_match_o && !resp_undef_o &&
      !resp_trap_mon_o && !resp_redirect_o)
    else $error("foreign encoding answered");
  redir_addr_a: assert property (
      take ##1 resp_redirect_o |-> resp_redirect_addr_o ==
      {$past(redirect_base_field_i), 12'h000} +
      ($past(req_op2_i) == 3'h3 ? 64'h958 : 64'h960))
    else $error("redirect address wrong");
  hyp_off_a: assert property (
      xlat_valid_i && !security_state_bit_i && !secure_hyp_level_enable_i
      |=> xlat_valid_o && !xlat_hit_o &&
      xlat_phys_id_o == $past(xlat_virt_id_i))
    else $error("translation while hyp level off");
  entry_valid_a: assert property (
      xlat_valid_i && xlat_virt_id_i < 16'h0020 &&
      !map_entry_valid_bits_i[xlat_virt_id_i[4:0]] |=> !xlat_hit_o)
    else $error("hit on invalid entry");
  // main scenarios
  cover_redir_c: cover property (take ##1 resp_redirect_o);
  cover_trap_c: cover property (take ##1 resp_trap_mon_o);
  cover_hit_c: cover property (xlat_valid_i ##1 xlat_hit_o);
endmodule // vpm_regs_checker

bind virt_part_map_regs vpm_regs_checker #(
  .HIGHEST_MAP_REG_INDEX(HIGHEST_MAP_REG_INDEX)
) u_vpm_regs_checker (
  .ref_clk_i, .arst_n_i, .req_valid_i, .req_level_i, .req_op0_i,
  .req_op2_i, .lower_level_trap_ctrl_i, .redirect_base_field_i,
  .security_state_bit_i, .secure_hyp_level_enable_i,
  .map_entry_valid_bits_i, .req_ready_o, .resp_valid_o, .resp_match_o,
  .resp_undef_o, .resp_trap_mon_o, .resp_redirect_o,
  .resp_redirect_addr_o, .highest_map_reg_index_o, .xlat_valid_i,
  .xlat_virt_id_i, .xlat_valid_o, .xlat_phys_id_o, .xlat_hit_o
);
`default_nettype wire
